/* logic/ocb_pkg.sv */
// package: offsets, field layout and reset values of the receive modem configuration bank
package ocb_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_FILTER_BW = 8'h1C;
   localparam logic [7:0] IDX_OVERSAMPLE = 8'h20;
   localparam logic [7:0] IDX_OFFSET_HIGH = 8'h21;
   localparam logic [7:0] IDX_OFFSET_MID = 8'h22;
   localparam logic [7:0] IDX_OFFSET_LOW = 8'h23;
   localparam logic [7:0] IDX_GAIN_HIGH = 8'h24;
   localparam logic [7:0] IDX_GAIN_LOW = 8'h25;
   localparam logic [7:0] IDX_RATE_HIGH = 8'h6E;
   localparam logic [7:0] IDX_RATE_LOW = 8'h6F;
   localparam logic [7:0] IDX_MOD_ONE = 8'h70;
   localparam logic [7:0] IDX_MOD_TWO = 8'h71;
   localparam logic [7:0] IDX_STATUS = 8'h72;
   localparam int ADDR_W = 10;
   // register 1Ch fields
   localparam int BW_BYPASS_BIT = 7;
   localparam int BW_DECIM_HI = 6;
   localparam int BW_DECIM_LO = 4;
   localparam int BW_FILSET_HI = 3;
   localparam int BW_FILSET_LO = 0;
   // register 21h fields: upper oversampling bits and upper offset bits
   localparam int OFS_OSR_HI = 7;
   localparam int OFS_OSR_LO = 5;
   localparam int OFS_NCO_HI = 3;
   localparam int OFS_NCO_LO = 0;
   localparam logic [7:0] OFS_USED_MASK = 8'hEF;
   // timing_loop_gain_high: upper gain bits
   localparam int GAIN_HI = 2;
   localparam logic [7:0] GAIN_USED_MASK = 8'h07;
   // register 70h fields
   localparam int MOD1_RATE_SCALE_BIT = 5;
   localparam int MOD1_MANCH_BIT = 1;
   localparam logic [7:0] MOD1_USED_MASK = 8'h22;
   // register 71h fields
   localparam int MOD2_TYPE_HI = 1;
   localparam int MOD2_TYPE_LO = 0;
   localparam logic [1:0] MODTYPE_OOK = 2'h1;
   // status register bits
   localparam int ST_OOK_BIT = 0;
   localparam int ST_BW_VALID_BIT = 1;
   localparam int ST_DOUBLE_BIT = 2;
   localparam int ST_SCALE_HINT_BIT = 3;
   // values after reset
   localparam logic [7:0] RST_FILTER_BW = 8'h00;
   localparam logic [7:0] RST_OVERSAMPLE = 8'h00;
   localparam logic [7:0] RST_OFFSET_HIGH = 8'h00;
   localparam logic [7:0] RST_OFFSET_MID = 8'h00;
   localparam logic [7:0] RST_OFFSET_LOW = 8'h00;
   localparam logic [7:0] RST_GAIN_HIGH = 8'h00;
   localparam logic [7:0] RST_GAIN_LOW = 8'h00;
   localparam logic [7:0] RST_RATE_HIGH = 8'h00;
   localparam logic [7:0] RST_RATE_LOW = 8'h00;
   localparam logic [7:0] RST_MOD_ONE = 8'h00;
   localparam logic [7:0] RST_MOD_TWO = 8'h00;
   // rate code at or below which the fine-scale bit is recommended
   localparam logic [15:0] SCALE_HINT_LIMIT = 16'h0F5C;
endpackage

/* logic/ocb_bw_check.sv */
// module: flags bandwidth encodings that the on-off-keying filter accepts
`timescale 1ns/100ps
module ocb_bw_check (
   input wire logic BYPASS,
   input wire logic [3:0] FILSET,
   output logic VALID
);
   import ocb_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // bypass clear: codes 1..7; bypass set: F, 1..4 and 8..14
   always_comb begin
      VALID = 1'b0;
      if (!BYPASS) begin
         VALID = (FILSET >= 4'h1) && (FILSET <= 4'h7);
      end else begin
         case (FILSET)
            4'hF, 4'h1, 4'h2, 4'h3, 4'h4: VALID = 1'b1;
            4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE: VALID = 1'b1;
            default: VALID = 1'b0;
         endcase
      end
   end
endmodule // ocb_bw_check

/* logic/ocb_config_bank.sv */
// module: apb register bank holding the on-off-keying receive modem configuration
`timescale 1ns/100ps
module ocb_config_bank (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [ocb_pkg::ADDR_W-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0] PSTRB,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   output logic OOK_ACTIVE,
   output logic DIV3_BYPASS_BIT,
   output logic [2:0] DECIM_EXP,
   output logic [3:0] FILTER_SELECT,
   output logic BW_VALID,
   output logic [15:0] BIT_RATE,
   output logic RATE_SCALE,
   output logic MANCH_ENABLE,
   output logic [16:0] EFFECTIVE_RATE,
   output logic [10:0] OVERSAMPLE,
   output logic [19:0] NCO_OFFSET,
   output logic [10:0] LOOP_GAIN
);
   import ocb_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // storage
   logic [7:0] filter_bw;
   logic [7:0] oversample_low;
   logic [7:0] offset_high;
   logic [7:0] offset_mid;
   logic [7:0] offset_low;
   logic [7:0] gain_high;
   logic [7:0] gain_low;
   logic [7:0] rate_high;
   logic [7:0] rate_low;
   logic [7:0] mod_one;
   logic [7:0] mod_two;
   logic [7:0] status;
   logic [7:0] next_read;
   logic next_err;
   logic bw_ok;

   ////////////////////////////////////////////////////////////////////////////
   // bus decode

   // register index carried by a byte address
   function automatic logic [7:0] word_idx(input logic [ADDR_W-1:0] addr);
      word_idx = addr[ADDR_W-1:2];
   endfunction

   // byte lanes other than the lowest never start a register
   function automatic logic aligned(input logic [ADDR_W-1:0] addr);
      aligned = (addr[1:0] == 2'h0);
   endfunction

   // true when the word address selects the given register index
   function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
      hit = aligned(addr) && (word_idx(addr) == idx);
   endfunction

   // true when the address falls on any implemented register
   function automatic logic mapped(input logic [ADDR_W-1:0] addr);
      mapped = hit(addr, IDX_FILTER_BW) || hit(addr, IDX_OVERSAMPLE)
         || hit(addr, IDX_OFFSET_HIGH) || hit(addr, IDX_OFFSET_MID)
         || hit(addr, IDX_OFFSET_LOW) || hit(addr, IDX_GAIN_HIGH)
         || hit(addr, IDX_GAIN_LOW) || hit(addr, IDX_RATE_HIGH)
         || hit(addr, IDX_RATE_LOW) || hit(addr, IDX_MOD_ONE)
         || hit(addr, IDX_MOD_TWO) || hit(addr, IDX_STATUS);
   endfunction

   logic setup;
   logic wr;
   // only the low lane carries register data; other lanes are don't care
   assign setup = PSEL && !PENABLE;
   assign wr = PSEL && PENABLE && PWRITE && PSTRB[0] && mapped(PADDR);

   // zero wait states: every access completes in its first access cycle
   assign PREADY = 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   // register writes, one process each

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         filter_bw <= RST_FILTER_BW;
      end else if (wr && hit(PADDR, IDX_FILTER_BW)) begin
         filter_bw <= PWDATA[7:0];
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         oversample_low <= RST_OVERSAMPLE;
      end else if (wr && hit(PADDR, IDX_OVERSAMPLE)) begin
         oversample_low <= PWDATA[7:0];
      end
   end

   // shared byte: both fields take the written value together
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         offset_high <= RST_OFFSET_HIGH;
      end else if (wr && hit(PADDR, IDX_OFFSET_HIGH)) begin
         offset_high <= PWDATA[7:0] & OFS_USED_MASK;
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         offset_mid <= RST_OFFSET_MID;
      end else if (wr && hit(PADDR, IDX_OFFSET_MID)) begin
         offset_mid <= PWDATA[7:0];
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         offset_low <= RST_OFFSET_LOW;
      end else if (wr && hit(PADDR, IDX_OFFSET_LOW)) begin
         offset_low <= PWDATA[7:0];
      end
   end

   // only three gain bits sit above the low byte
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         gain_high <= RST_GAIN_HIGH;
      end else if (wr && hit(PADDR, IDX_GAIN_HIGH)) begin
         gain_high <= PWDATA[7:0] & GAIN_USED_MASK;
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         gain_low <= RST_GAIN_LOW;
      end else if (wr && hit(PADDR, IDX_GAIN_LOW)) begin
         gain_low <= PWDATA[7:0];
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         rate_high <= RST_RATE_HIGH;
      end else if (wr && hit(PADDR, IDX_RATE_HIGH)) begin
         rate_high <= PWDATA[7:0];
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         rate_low <= RST_RATE_LOW;
      end else if (wr && hit(PADDR, IDX_RATE_LOW)) begin
         rate_low <= PWDATA[7:0];
      end
   end

   // unused bits of the mode bytes read back as zero
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         mod_one <= RST_MOD_ONE;
      end else if (wr && hit(PADDR, IDX_MOD_ONE)) begin
         mod_one <= PWDATA[7:0] & MOD1_USED_MASK;
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         mod_two <= RST_MOD_TWO;
      end else if (wr && hit(PADDR, IDX_MOD_TWO)) begin
         mod_two <= {6'h00, PWDATA[MOD2_TYPE_HI:MOD2_TYPE_LO]};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bandwidth encoding check

   ocb_bw_check u_bw_check (
      .BYPASS(filter_bw[BW_BYPASS_BIT]),
      .FILSET(filter_bw[BW_FILSET_HI:BW_FILSET_LO]),
      .VALID(bw_ok)
   );

   ////////////////////////////////////////////////////////////////////////////
   // status byte, read only; writes to it are ignored
   // status lags the registers by one edge, the same as the outputs

   logic ook_sel;
   logic manch;
   logic [15:0] rate;
   assign ook_sel = (mod_two[MOD2_TYPE_HI:MOD2_TYPE_LO] == MODTYPE_OOK);
   assign manch = mod_one[MOD1_MANCH_BIT];
   assign rate = {rate_high, rate_low};

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         status <= 8'h00;
      end else begin
         status <= 8'h00;
         status[ST_OOK_BIT] <= ook_sel;
         status[ST_BW_VALID_BIT] <= bw_ok;
         status[ST_DOUBLE_BIT] <= manch;
         // hint only: the bank never forces the scale bit itself
         status[ST_SCALE_HINT_BIT] <= (rate <= SCALE_HINT_LIMIT)
            && !mod_one[MOD1_RATE_SCALE_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read path: data latched in the setup cycle, held through the access

   always_comb begin
      next_read = 8'h00;
      case (word_idx(PADDR))
         IDX_FILTER_BW: next_read = filter_bw;
         IDX_OVERSAMPLE: next_read = oversample_low;
         IDX_OFFSET_HIGH: next_read = offset_high;
         IDX_OFFSET_MID: next_read = offset_mid;
         IDX_OFFSET_LOW: next_read = offset_low;
         IDX_GAIN_HIGH: next_read = gain_high;
         IDX_GAIN_LOW: next_read = gain_low;
         IDX_RATE_HIGH: next_read = rate_high;
         IDX_RATE_LOW: next_read = rate_low;
         IDX_MOD_ONE: next_read = mod_one;
         IDX_MOD_TWO: next_read = mod_two;
         IDX_STATUS: next_read = status;
         default: next_read = 8'h00;
      endcase
      if (!aligned(PADDR)) begin
         next_read = 8'h00;
      end
   end

   // unmapped or misaligned addresses answer with an error and no effect
   assign next_err = !mapped(PADDR);

   // latched at setup so the access edge sees settled data
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         PRDATA <= 32'h0000_0000;
      end else if (setup && !PWRITE) begin
         PRDATA <= {24'h00_0000, next_read};
      end
   end

   // error stands for the access cycle only, then drops
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         PSLVERR <= 1'b0;
      end else if (setup) begin
         PSLVERR <= next_err;
      end else if (PSEL && PENABLE) begin
         PSLVERR <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // modem-facing fields, registered; idle at zero unless on-off-keying is
   // selected so a stale frequency-shift setup never reaches the demodulator
   // no shadow copy: a multi-byte field shows a mixed value between its byte
   // writes, so software fills the fields before it selects on-off-keying

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         OOK_ACTIVE <= 1'b0;
      end else begin
         OOK_ACTIVE <= ook_sel;
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         BIT_RATE <= 16'h0000;
         RATE_SCALE <= 1'b0;
         MANCH_ENABLE <= 1'b0;
         EFFECTIVE_RATE <= 17'h0_0000;
      end else if (ook_sel) begin
         BIT_RATE <= rate;
         RATE_SCALE <= mod_one[MOD1_RATE_SCALE_BIT];
         MANCH_ENABLE <= manch;
         // doubled rate feeds decimation and timing recovery
         EFFECTIVE_RATE <= manch ? {rate, 1'b0} : {1'b0, rate};
      end else begin
         BIT_RATE <= 16'h0000;
         RATE_SCALE <= 1'b0;
         MANCH_ENABLE <= 1'b0;
         EFFECTIVE_RATE <= 17'h0_0000;
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         DIV3_BYPASS_BIT <= 1'b0;
         DECIM_EXP <= 3'h0;
         FILTER_SELECT <= 4'h0;
         BW_VALID <= 1'b0;
      end else if (ook_sel) begin
         DIV3_BYPASS_BIT <= filter_bw[BW_BYPASS_BIT];
         DECIM_EXP <= filter_bw[BW_DECIM_HI:BW_DECIM_LO];
         FILTER_SELECT <= filter_bw[BW_FILSET_HI:BW_FILSET_LO];
         BW_VALID <= bw_ok;
      end else begin
         DIV3_BYPASS_BIT <= 1'b0;
         DECIM_EXP <= 3'h0;
         FILTER_SELECT <= 4'h0;
         BW_VALID <= 1'b0;
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         OVERSAMPLE <= 11'h000;
         NCO_OFFSET <= 20'h0_0000;
         LOOP_GAIN <= 11'h000;
      end else if (ook_sel) begin
         OVERSAMPLE <= {offset_high[OFS_OSR_HI:OFS_OSR_LO], oversample_low};
         NCO_OFFSET <= {offset_high[OFS_NCO_HI:OFS_NCO_LO], offset_mid, offset_low};
         LOOP_GAIN <= {gain_high[GAIN_HI:0], gain_low};
      end else begin
         OVERSAMPLE <= 11'h000;
         NCO_OFFSET <= 20'h0_0000;
         LOOP_GAIN <= 11'h000;
      end
   end
endmodule // ocb_config_bank

/* dv/ocb_config_bank_monitor.sv */
// checker: concurrent properties on the configuration bank ports
`timescale 1ns/100ps
module ocb_config_bank_monitor (
   input logic CLK,
   input logic RSTN,
   input logic PSEL,
   input logic PENABLE,
   input logic PWRITE,
   input logic [ocb_pkg::ADDR_W-1:0] PADDR,
   input logic [31:0] PWDATA,
   input logic [3:0] PSTRB,
   input logic [31:0] PRDATA,
   input logic PREADY,
   input logic PSLVERR,
   input logic OOK_ACTIVE,
   input logic DIV3_BYPASS_BIT,
   input logic [2:0] DECIM_EXP,
   input logic [3:0] FILTER_SELECT,
   input logic BW_VALID,
   input logic [15:0] BIT_RATE,
   input logic RATE_SCALE,
   input logic MANCH_ENABLE,
   input logic [16:0] EFFECTIVE_RATE,
   input logic [10:0] OVERSAMPLE,
   input logic [19:0] NCO_OFFSET,
   input logic [10:0] LOOP_GAIN
);
   import ocb_pkg::*;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);
   logic wr;
   logic [7:0] widx;
   assign wr = PSEL && PENABLE && PWRITE && PSTRB[0] && (PADDR[1:0] == 2'h0);
   assign widx = PADDR[ADDR_W-1:2];
   function automatic logic ok_bw(input logic b, input logic [3:0] f);
      ok_bw = b ? (f == 4'hF || (f >= 4'h1 && f <= 4'h4) || (f >= 4'h8 && f <= 4'hE))
                : (f >= 4'h1 && f <= 4'h7);
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   AST_OOK_SELECT: assert property (
      wr && widx == IDX_MOD_TWO |-> ##2 OOK_ACTIVE == ($past(PWDATA[1:0], 2) == MODTYPE_OOK))
      else $error("ook flag does not follow modulation type write");
   AST_OFF_ZERO: assert property (
      !OOK_ACTIVE && $past(!OOK_ACTIVE) |-> (BIT_RATE == 16'h0000 && OVERSAMPLE == 11'h000
      && NCO_OFFSET == 20'h00000 && LOOP_GAIN == 11'h000 && !MANCH_ENABLE))
      else $error("modem outputs not zero without ook");
   AST_RATE_HIGH: assert property (
      wr && widx == IDX_RATE_HIGH && OOK_ACTIVE |-> ##2
      (!OOK_ACTIVE || BIT_RATE[15:8] == $past(PWDATA[7:0], 2)))
      else $error("rate high byte not placed");
   AST_RATE_LOW: assert property (
      wr && widx == IDX_RATE_LOW && OOK_ACTIVE |-> ##2
      (!OOK_ACTIVE || BIT_RATE[7:0] == $past(PWDATA[7:0], 2)))
      else $error("rate low byte not placed");
   AST_MANCH_EFFECTIVE: assert property (
      $stable(BIT_RATE) && $stable(MANCH_ENABLE) |->
      EFFECTIVE_RATE == (MANCH_ENABLE ? {BIT_RATE, 1'b0} : {1'b0, BIT_RATE}))
      else $error("effective rate wrong");
   AST_MANCH_BIT: assert property (
      wr && widx == IDX_MOD_ONE && OOK_ACTIVE |-> ##2
      (!OOK_ACTIVE || {RATE_SCALE, MANCH_ENABLE} == {$past(PWDATA[5], 2), $past(PWDATA[1], 2)}))
      else $error("manchester or scale bit wrong");
   AST_BW_FIELDS: assert property (
      wr && widx == IDX_FILTER_BW && OOK_ACTIVE |-> ##2
      (!OOK_ACTIVE || {DIV3_BYPASS_BIT, DECIM_EXP, FILTER_SELECT} == $past(PWDATA[7:0], 2)))
      else $error("filter fields wrong");
   AST_BW_VALID: assert property (
      (OOK_ACTIVE && $stable({DIV3_BYPASS_BIT, FILTER_SELECT}))[*2] |->
      BW_VALID == ok_bw(DIV3_BYPASS_BIT, FILTER_SELECT))
      else $error("bandwidth valid flag wrong");
   AST_OSR_LOW: assert property (
      wr && widx == IDX_OVERSAMPLE && OOK_ACTIVE |-> ##2
      (!OOK_ACTIVE || OVERSAMPLE[7:0] == $past(PWDATA[7:0], 2)))
      else $error("oversample low byte wrong");
   AST_SHARED_REG: assert property (
      wr && widx == IDX_OFFSET_HIGH && OOK_ACTIVE |-> ##2 (!OOK_ACTIVE ||
      (OVERSAMPLE[10:8] == $past(PWDATA[7:5], 2) && NCO_OFFSET[19:16] == $past(PWDATA[3:0], 2))))
      else $error("shared register split wrong");
   AST_NCO_LOW: assert property (
      wr && widx == IDX_OFFSET_LOW && OOK_ACTIVE |-> ##2
      (!OOK_ACTIVE || NCO_OFFSET[7:0] == $past(PWDATA[7:0], 2)))
      else $error("offset low byte wrong");
   AST_GAIN_HIGH: assert property (
      wr && widx == IDX_GAIN_HIGH && OOK_ACTIVE |-> ##2
      (!OOK_ACTIVE || LOOP_GAIN[10:8] == $past(PWDATA[2:0], 2)))
      else $error("gain high bits wrong");
   cover property (wr && widx == IDX_OFFSET_HIGH && OOK_ACTIVE);
   cover property (OOK_ACTIVE && MANCH_ENABLE);
   cover property (OOK_ACTIVE && BW_VALID && DIV3_BYPASS_BIT);
endmodule // ocb_config_bank_monitor
////////////////////////////////////////////////////////////////////////////////
bind ocb_config_bank ocb_config_bank_monitor u_ocb_config_bank_monitor (
   .CLK(CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
   .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .OOK_ACTIVE(OOK_ACTIVE), .DIV3_BYPASS_BIT(DIV3_BYPASS_BIT), .DECIM_EXP(DECIM_EXP),
   .FILTER_SELECT(FILTER_SELECT), .BW_VALID(BW_VALID), .BIT_RATE(BIT_RATE),
   .RATE_SCALE(RATE_SCALE), .MANCH_ENABLE(MANCH_ENABLE), .EFFECTIVE_RATE(EFFECTIVE_RATE),
   .OVERSAMPLE(OVERSAMPLE), .NCO_OFFSET(NCO_OFFSET), .LOOP_GAIN(LOOP_GAIN));

/* dv/ocb_config_bank_bench.sv */
// testbench: apb register tests of the receive modem configuration bank
`timescale 1ns/100ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
   $display("BAD %s expected %0h seen %0h", nm, e, g); end end
module ocb_config_bank_bench;
   import ocb_pkg::*;
   logic clk, rstn, psel, penable, pwrite, pready, pslverr, ook_active, div3_bypass_bit;
   logic bw_valid, rate_scale, manch_enable, rerr, exp_ok;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic [3:0] pstrb, filter_select;
   logic [2:0] decim_exp;
   logic [15:0] bit_rate;
   logic [16:0] effective_rate;
   logic [10:0] oversample, loop_gain;
   logic [19:0] nco_offset;
   int failures, cmp_count;
   logic [7:0] idx_list [0:10] = '{IDX_FILTER_BW, IDX_OVERSAMPLE, IDX_OFFSET_HIGH,
      IDX_OFFSET_MID, IDX_OFFSET_LOW, IDX_GAIN_HIGH, IDX_GAIN_LOW, IDX_RATE_HIGH,
      IDX_RATE_LOW, IDX_MOD_ONE, IDX_MOD_TWO};
   // bits that read back after writing all ones
   logic [7:0] mask_list [0:10] = '{8'hFF, 8'hFF, 8'hEF, 8'hFF, 8'hFF, 8'h07, 8'hFF, 8'hFF,
      8'hFF, 8'h22, 8'h03};
   ocb_config_bank u_ocb_config_bank (
      .CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .OOK_ACTIVE(ook_active), .DIV3_BYPASS_BIT(div3_bypass_bit), .DECIM_EXP(decim_exp),
      .FILTER_SELECT(filter_select), .BW_VALID(bw_valid), .BIT_RATE(bit_rate),
      .RATE_SCALE(rate_scale), .MANCH_ENABLE(manch_enable), .EFFECTIVE_RATE(effective_rate),
      .OVERSAMPLE(oversample), .NCO_OFFSET(nco_offset), .LOOP_GAIN(loop_gain));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      xfer(1'b1, {i, 2'h0}, {24'h000000, d});
   endtask
   task automatic rd_chk(input string nm, input logic [7:0] i, input logic [7:0] e);
      xfer(1'b0, {i, 2'h0}, 32'h00000000);
      `CHK(nm, {24'h000000, e}, rdat)
      `CHK("slverr", 1'b0, rerr)
   endtask
   // outputs and status both lag the register by one edge
   task automatic settle;
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #200000;
      failures++;
      $display("watchdog expired");
      wrap_up;
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rstn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      pstrb = 4'hF;
      failures = 0;
      cmp_count = 0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      for (int k = 0; k < 11; k++) rd_chk("reset", idx_list[k], 8'h00);
      for (int k = 0; k < 11; k++) begin
         wr(idx_list[k], 8'hFF);
         rd_chk("mask", idx_list[k], mask_list[k]);
      end
      $display("test registers done");
      for (int m = 0; m < 4; m++) begin
         wr(IDX_MOD_TWO, 8'(m));
         settle;
         `CHK("ook", logic'(m == 1), ook_active)
         `CHK("rate_gate", (m == 1) ? 16'hFFFF : 16'h0000, bit_rate)
      end
      $display("test modulation done");
      // 9.6 kbps, manchester off, 335.5 kHz worked example
      wr(IDX_MOD_TWO, 8'h01);
      wr(IDX_MOD_ONE, 8'h00);
      wr(IDX_FILTER_BW, 8'h98);
      wr(IDX_OVERSAMPLE, 8'h71);
      wr(IDX_OFFSET_HIGH, 8'h40);
      wr(IDX_OFFSET_MID, 8'h34);
      wr(IDX_OFFSET_LOW, 8'h6E);
      wr(IDX_GAIN_HIGH, 8'h00);
      wr(IDX_GAIN_LOW, 8'h6B);
      wr(IDX_RATE_HIGH, 8'h0F);
      wr(IDX_RATE_LOW, 8'h5C);
      settle;
      `CHK("fields", 8'h98, {div3_bypass_bit, decim_exp, filter_select})
      `CHK("osr", 11'h271, oversample)
      `CHK("nco", 20'h0346E, nco_offset)
      `CHK("gain", 11'h06B, loop_gain)
      `CHK("rate", 16'h0F5C, bit_rate)
      `CHK("eff", 17'h00F5C, effective_rate)
      rd_chk("status", IDX_STATUS, 8'h0B);
      wr(IDX_MOD_ONE, 8'h02);
      settle;
      `CHK("eff_manch", 17'h01EB8, effective_rate)
      rd_chk("status_manch", IDX_STATUS, 8'h0F);
      wr(IDX_MOD_ONE, 8'h20);
      settle;
      `CHK("scale", 2'h2, {rate_scale, manch_enable})
      rd_chk("status_scale", IDX_STATUS, 8'h03);
      wr(IDX_MOD_ONE, 8'h00);
      wr(IDX_RATE_LOW, 8'h5D);
      rd_chk("status_limit", IDX_STATUS, 8'h03);
      wr(IDX_OFFSET_HIGH, 8'hEF);
      settle;
      `CHK("osr_shared", 11'h771, oversample)
      `CHK("nco_shared", 20'hF346E, nco_offset)
      wr(IDX_GAIN_HIGH, 8'hFD);
      settle;
      `CHK("gain_high", 11'h56B, loop_gain)
      $display("test example done");
      for (int c = 0; c < 32; c++) begin
         exp_ok = c[4] ? (c[3:0] == 4'hF || (c[3:0] >= 1 && c[3:0] <= 4) ||
            (c[3:0] >= 8 && c[3:0] <= 14)) : (c[3:0] >= 1 && c[3:0] <= 7);
         wr(IDX_FILTER_BW, {c[4], c[2:0], c[3:0]});
         settle;
         `CHK("bw_valid", exp_ok, bw_valid)
         `CHK("decim", 3'(c), decim_exp)
      end
      $display("test bandwidth done");
      xfer(1'b0, 10'h3FC, 32'h00000000);
      `CHK("unmapped_err", 1'b1, rerr)
      `CHK("unmapped_data", 32'h00000000, rdat)
      xfer(1'b1, {IDX_RATE_LOW, 2'h1}, 32'h000000AA);
      `CHK("misaligned_err", 1'b1, rerr)
      wr(IDX_STATUS, 8'hFF);
      rd_chk("status_ro", IDX_STATUS, 8'h03);
      pstrb <= 4'hE;
      wr(IDX_RATE_LOW, 8'h11);
      pstrb <= 4'hF;
      rd_chk("strobe_off", IDX_RATE_LOW, 8'h5D);
      wr(IDX_MOD_TWO, 8'h02);
      settle;
      `CHK("off_nco", 20'h00000, nco_offset)
      `CHK("off_osr", 11'h000, oversample)
      $display("test refusal done");
      wrap_up;
   end
endmodule // ocb_config_bank_bench
